// ===== rtl/osil_core.sv
// device-side register ownership, selection and interrupt logic
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - after reset the device runs in legacy mode until overlap is enabled
// - legacy: once a command is taken, busy or data request stays set to completion
// - overlap, non-data command: busy stays set from acceptance to completion
// - overlap data command: set busy, block writes, latch parameters, clear busy
// - legacy and device-bit mode: respond only when head DEV bit matches position
// - legacy: cs0 negated cs1 asserted is control, reverse is command block
// - chip-select mode: four chip select codes pick each device's two blocks
// - device-bit mode: shared interrupt line, driven only while selected
// - chip-select mode: device 0 uses interrupt, device 1 the second interrupt pin
// - chip-select mode: interrupt may be asserted whether or not selected
// - mode kept until feature clear, hard reset; soft reset aborts queue, idles the command, clears pending interrupt
//////////////////////////////////////////////////////////////////////////////
module osil_core
  import osil_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // host cable pins
  input wire logic cs0_n_pin,
  input wire logic cs1_n_pin,
  input wire logic diow_n_pin,
  input wire logic dior_n_pin,
  input wire logic [2:0] da_pin,
  input wire logic [7:0] dd_in,
  output logic [7:0] dd_out,
  output logic dd_oe_n,
  output logic intrq_out,
  output logic intrq_oe_n,
  output logic second_device_interrupt_out,
  output logic second_device_interrupt_oe_n,
  // configuration
  input wire logic position_strap,
  // firmware side
  input wire logic fw_mode_set,
  input wire logic [1:0] fw_mode_sel,
  input wire logic fw_class_valid,
  input wire logic fw_class_data,
  input wire logic fw_drq_set,
  input wire logic fw_drq_clr,
  input wire logic fw_done,
  input wire logic fw_error,
  input wire logic fw_intr_req,
  output osil_mode_t mode,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic param_valid,
  output logic [7:0] param_features,
  output logic [7:0] param_count,
  output logic [7:0] param_sector,
  output logic [7:0] param_cyl_lo,
  output logic [7:0] param_cyl_hi,
  output logic [7:0] param_head,
  output logic queue_abort,
  output logic soft_reset
);

  //////////////////////////////////////////////////////////////////////////////
  // decode of chip selects into this device's blocks; {command, control}
  function automatic logic [1:0] blk_hit(input osil_mode_t m, input logic cs0a,
                                         input logic cs1a, input logic pos,
                                         input logic dev_sel);
    logic [1:0] r;
    r = 2'h0;
    if (m == OSIL_CHIP_SELECT_DECODE_MODE)
    begin
      // cs1 asserted means device 1; cs0 asserted means command block
      if (cs1a == pos)
      begin
        r = {cs0a, ~cs0a};
      end
    end
    else
    begin
      // selection follows the head register DEV bit
      if (dev_sel == pos)
      begin
        r = {cs0a & ~cs1a, ~cs0a & cs1a};
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // three-stage pin synchroniser; a bit changes once stages two and three agree
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] pin_q;

  assign pin_raw = {cs0_n_pin, cs1_n_pin, diow_n_pin, dior_n_pin, da_pin, dd_in};

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s1_q <= {PIN_W{1'b1}};
      s2_q <= {PIN_W{1'b1}};
      s3_q <= {PIN_W{1'b1}};
      pin_q <= {PIN_W{1'b1}};
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < PIN_W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic cs0_nq;
  logic cs1_nq;
  logic cs0a;
  logic cs1a;
  logic wr_n;
  logic rd_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr_n_prev_q;

  // unpack in the same order as the synchroniser packs the pins
  assign {cs0_nq, cs1_nq, wr_n, rd_n, addr, wdata} = pin_q;
  assign cs0a = ~cs0_nq;
  assign cs1a = ~cs1_nq;

  //////////////////////////////////////////////////////////////////////////////
  // position strap caught after reset release, never under reset
  logic pos_q;
  logic pos_taken_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pos_taken_q <= 1'b0;
      pos_q <= 1'b0;
    end
    else if (!pos_taken_q)
    begin
      pos_taken_q <= 1'b1;
      pos_q <= position_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shadow registers and decoded write strobes
  logic [7:0] features_q;
  logic [7:0] count_q;
  logic [7:0] sector_q;
  logic [7:0] cyl_lo_q;
  logic [7:0] cyl_hi_q;
  logic [7:0] head_q;
  logic [7:0] ctrl_q;
  logic [1:0] hit;
  logic wr_edge;
  logic cmd_wr;
  logic ctrl_wr;
  logic shadow_wr;
  logic owned;
  osil_state_t state_q;

  assign hit = blk_hit(mode, cs0a, cs1a, pos_q, head_q[HEAD_DEV_BIT]);
  assign wr_edge = wr_n & ~wr_n_prev_q;
  // while busy or data request is shown the device owns its command block
  assign owned = (state_q != ST_IDLE) && (state_q != ST_RELEASE);
  // legacy head writes reach both devices so each can track the DEV bit
  assign shadow_wr = wr_edge && cs0a && !cs1a && !owned &&
                     (hit[1] || (mode != OSIL_CHIP_SELECT_DECODE_MODE));
  assign cmd_wr = wr_edge && hit[1] && !owned && (addr == REG_COMMAND);
  assign ctrl_wr = wr_edge && hit[0] && (addr == REG_DEV_CTRL);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_n_prev_q <= 1'b1;
    end
    else
    begin
      wr_n_prev_q <= wr_n;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      features_q <= BYTE_RST;
      count_q <= BYTE_RST;
      sector_q <= BYTE_RST;
      cyl_lo_q <= BYTE_RST;
      cyl_hi_q <= BYTE_RST;
      head_q <= HEAD_RST;
    end
    else if (shadow_wr)
    begin
      case (addr)
        REG_FEATURES: features_q <= wdata;
        REG_COUNT: count_q <= wdata;
        REG_SECTOR: sector_q <= wdata;
        REG_CYL_LO: cyl_lo_q <= wdata;
        REG_CYL_HI: cyl_hi_q <= wdata;
        REG_HEAD: head_q <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= BYTE_RST;
    end
    else if (ctrl_wr)
    begin
      ctrl_q <= wdata;
    end
  end

  // soft reset pulses on the rising edge of the reset bit
  logic srst_hit;
  assign srst_hit = ctrl_wr && wdata[CTRL_SRST_BIT] && !ctrl_q[CTRL_SRST_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // mode: legacy from reset, changed only by the feature command path
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode <= OSIL_LEGACY;
    end
    else if (fw_mode_set)
    begin
      case (fw_mode_sel)
        2'h1: mode <= OSIL_DEVICE_BIT_SELECT_MODE;
        2'h2: mode <= OSIL_CHIP_SELECT_DECODE_MODE;
        default: mode <= OSIL_LEGACY;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      queue_abort <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      // a soft reset aborts the queue but leaves the mode alone
      queue_abort <= srst_hit || fw_mode_set;
      soft_reset <= srst_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command ownership sequence
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || srst_hit)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE, ST_RELEASE:
        begin
          state_q <= cmd_wr ? ST_ENTRY : ST_IDLE;
        end
        ST_ENTRY:
        begin
          // busy set and writes blocked until firmware classifies the command
          if (fw_class_valid)
          begin
            if (fw_class_data && (mode != OSIL_LEGACY))
            begin
              state_q <= ST_LATCH;
            end
            else
            begin
              state_q <= ST_BUSY;
            end
          end
        end
        ST_LATCH: state_q <= ST_RELEASE;
        ST_BUSY:
        begin
          if (fw_done)
          begin
            state_q <= ST_IDLE;
          end
          else if (fw_drq_set)
          begin
            state_q <= ST_DRQ;
          end
        end
        ST_DRQ:
        begin
          // no gap between data request and busy, so the host never sees both clear
          if (fw_done)
          begin
            state_q <= ST_IDLE;
          end
          else if (fw_drq_clr)
          begin
            state_q <= ST_BUSY;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // parameters copied only after writes are blocked, so busy can drop early
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      param_valid <= 1'b0;
      param_features <= BYTE_RST;
      param_count <= BYTE_RST;
      param_sector <= BYTE_RST;
      param_cyl_lo <= BYTE_RST;
      param_cyl_hi <= BYTE_RST;
      param_head <= BYTE_RST;
    end
    else
    begin
      param_valid <= (state_q == ST_LATCH);
      if (state_q == ST_LATCH)
      begin
        param_features <= features_q;
        param_count <= count_q;
        param_sector <= sector_q;
        param_cyl_lo <= cyl_lo_q;
        param_cyl_hi <= cyl_hi_q;
        param_head <= head_q;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      cmd_opcode <= BYTE_RST;
    end
    else
    begin
      cmd_valid <= cmd_wr;
      if (cmd_wr)
      begin
        cmd_opcode <= wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status, error and interrupt pending
  logic err_q;
  logic pend_q;
  logic stat_rd;
  logic rd_n_prev_q;
  logic [7:0] status;

  assign stat_rd = !rd_n && rd_n_prev_q && hit[1] && (addr == REG_COMMAND);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_n_prev_q <= 1'b1;
      err_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      rd_n_prev_q <= rd_n;
      if (fw_done)
      begin
        err_q <= fw_error;
      end
      else if (cmd_wr)
      begin
        err_q <= 1'b0;
      end
      // a new request wins over a status read or command write in the same cycle
      if (fw_intr_req)
      begin
        pend_q <= 1'b1;
      end
      else if (stat_rd || cmd_wr || srst_hit)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  always_comb
  begin
    status = BYTE_RST;
    status[STAT_BSY_BIT] = (state_q == ST_ENTRY) || (state_q == ST_LATCH) ||
                           (state_q == ST_BUSY);
    status[STAT_DRDY_BIT] = 1'b1;
    status[STAT_DRQ_BIT] = (state_q == ST_DRQ);
    status[STAT_ERR_BIT] = err_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path, driven only while this device's block is read
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dd_out <= BYTE_RST;
      dd_oe_n <= 1'b1;
    end
    else
    begin
      dd_oe_n <= ~(!rd_n && (hit != 2'h0));
      if (hit[0])
      begin
        dd_out <= (addr == REG_DEV_CTRL) ? status : BYTE_RST;
      end
      else
      begin
        case (addr)
          REG_FEATURES: dd_out <= {7'h00, err_q};
          REG_COUNT: dd_out <= count_q;
          REG_SECTOR: dd_out <= sector_q;
          REG_CYL_LO: dd_out <= cyl_lo_q;
          REG_CYL_HI: dd_out <= cyl_hi_q;
          REG_HEAD: dd_out <= head_q;
          REG_COMMAND: dd_out <= status;
          default: dd_out <= BYTE_RST;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt pins; oe_n low means this device drives the line
  logic irq_lvl;
  logic selected;
  assign irq_lvl = pend_q && !ctrl_q[CTRL_NIEN_BIT];
  assign selected = (head_q[HEAD_DEV_BIT] == pos_q);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      intrq_out <= 1'b0;
      intrq_oe_n <= 1'b1;
      second_device_interrupt_out <= 1'b0;
      second_device_interrupt_oe_n <= 1'b1;
    end
    else if (mode == OSIL_CHIP_SELECT_DECODE_MODE)
    begin
      // each device owns its own line, so selection no longer gates it
      intrq_out <= irq_lvl && !pos_q;
      intrq_oe_n <= pos_q;
      second_device_interrupt_out <= irq_lvl && pos_q;
      second_device_interrupt_oe_n <= ~pos_q;
    end
    else
    begin
      // shared line: the unselected device lets go entirely
      intrq_out <= irq_lvl && selected;
      intrq_oe_n <= ~selected;
      second_device_interrupt_out <= 1'b0;
      second_device_interrupt_oe_n <= 1'b1;
    end
  end

endmodule

// ===== rtl/osil_pkg.sv
// constants and types for the overlap select and interrupt logic
package osil_pkg;

  // command block register indices on the address lines
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_FEATURES = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_SECTOR = 3'h3;
  localparam logic [2:0] REG_CYL_LO = 3'h4;
  localparam logic [2:0] REG_CYL_HI = 3'h5;
  localparam logic [2:0] REG_HEAD = 3'h6;
  localparam logic [2:0] REG_COMMAND = 3'h7;
  // control block: device control on write, alternate status on read
  localparam logic [2:0] REG_DEV_CTRL = 3'h6;

  // field positions
  localparam int HEAD_DEV_BIT = 4;
  localparam int CTRL_SRST_BIT = 2;
  localparam int CTRL_NIEN_BIT = 1;
  localparam int STAT_BSY_BIT = 7;
  localparam int STAT_DRDY_BIT = 6;
  localparam int STAT_DRQ_BIT = 3;
  localparam int STAT_ERR_BIT = 0;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] HEAD_RST = 8'hA0;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // number of synchronised pin bits: cs0, cs1, diow, dior, da[2:0], dd[7:0]
  localparam int PIN_W = 15;

  typedef enum logic [1:0]
  {
    OSIL_LEGACY = 2'h0,
    OSIL_DEVICE_BIT_SELECT_MODE = 2'h1,
    OSIL_CHIP_SELECT_DECODE_MODE = 2'h2
  } osil_mode_t;

  // gray along idle, entry, latch, release; busy and data request off that path
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ENTRY = 3'h1,
    ST_LATCH = 3'h3,
    ST_RELEASE = 3'h2,
    ST_BUSY = 3'h6,
    ST_DRQ = 3'h7
  } osil_state_t;

endpackage

// ===== verification/osil_chk.sv
// assertion checker for the overlap select and interrupt logic
`timescale 1ns/1ps
module osil_chk
  import osil_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs0_n_pin,
  input wire logic cs1_n_pin,
  input wire logic dior_n_pin,
  input wire logic position_strap,
  input wire logic fw_mode_set,
  input wire logic fw_intr_req,
  input wire osil_mode_t mode,
  input wire logic param_valid,
  input wire logic [7:0] param_count,
  input wire logic dd_oe_n,
  input wire logic intrq_out,
  input wire logic intrq_oe_n,
  input wire logic second_device_interrupt_oe_n,
  input wire logic queue_abort
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  chk_reset_legacy: assert property ($rose(rst_n) |-> mode == OSIL_LEGACY)
    else $error("mode not legacy after reset");
  chk_mode_persist: assert property ($changed(mode) |->
    $past(fw_mode_set) || $past(fw_mode_set, 2))
    else $error("mode changed without a mode set");
  chk_abort_mode: assert property (fw_mode_set |-> ##[1:2] queue_abort)
    else $error("mode set did not abort queue");
  chk_param_overlap: assert property (param_valid |-> mode != OSIL_LEGACY)
    else $error("parameters latched in legacy mode");
  chk_param_latched: assert property ($changed(param_count) |-> ##[0:2] param_valid)
    else $error("parameter changed outside a latch");
  // device 0 and every non decode mode leave the second line alone
  chk_sec_idle: assert property ((mode != OSIL_CHIP_SELECT_DECODE_MODE || !position_strap) [*2]
    |-> second_device_interrupt_oe_n)
    else $error("second interrupt driven");
  chk_cs_intr: assert property (mode == OSIL_CHIP_SELECT_DECODE_MODE && !position_strap
    && fw_intr_req |-> ##[1:3] (!intrq_oe_n && intrq_out))
    else $error("decode mode interrupt not raised");
  chk_dd_release: assert property (dior_n_pin [*8] |-> dd_oe_n)
    else $error("data bus held after read");
  chk_dd_unused: assert property ((mode == OSIL_LEGACY && cs0_n_pin == cs1_n_pin) [*8]
    |-> dd_oe_n)
    else $error("data bus driven on unused select");
  cov_param: cover property (param_valid);
  cov_sec_int: cover property (!second_device_interrupt_oe_n);
  cov_cs_intr: cover property (mode == OSIL_CHIP_SELECT_DECODE_MODE && fw_intr_req);
endmodule
bind osil_core osil_chk u_chk(.sys_clk(sys_clk), .rst_n(rst_n), .cs0_n_pin(cs0_n_pin),
  .cs1_n_pin(cs1_n_pin), .dior_n_pin(dior_n_pin), .position_strap(position_strap),
  .fw_mode_set(fw_mode_set), .fw_intr_req(fw_intr_req), .mode(mode),
  .param_valid(param_valid), .param_count(param_count), .dd_oe_n(dd_oe_n),
  .intrq_out(intrq_out), .intrq_oe_n(intrq_oe_n),
  .second_device_interrupt_oe_n(second_device_interrupt_oe_n), .queue_abort(queue_abort));

// ===== verification/osil_host_model.sv
// host adapter model driving the cable pins
`timescale 1ns/1ps
module osil_host_model
(
  input wire logic sys_clk,
  input wire logic [7:0] dd_out,
  input wire logic dd_oe_n,
  output logic cs0_n,
  output logic cs1_n,
  output logic diow_n,
  output logic dior_n,
  output logic [2:0] da,
  output logic [7:0] dd
);
  logic drv;
  logic [7:0] wd;
  logic [7:0] last = 8'h00;
  // undriven bus shows a changing pattern, never a held value
  assign dd = !dd_oe_n ? dd_out : (drv ? wd : ~last);
  always @(posedge sys_clk) last <= dd;
  initial
  begin
    {cs0_n, cs1_n, diow_n, dior_n, drv} = 5'h1E;
    da = 3'h0;
    wd = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // strobes and gaps kept long enough for the pin filter
  task automatic wr(input logic c0, input logic c1, input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {cs0_n, cs1_n, da, wd, drv} = {c0, c1, a, d, 1'b1};
    repeat (4) @(negedge sys_clk);
    diow_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    diow_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    {cs0_n, cs1_n, drv} = 3'h6;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic rd(input logic c0, input logic c1, input logic [2:0] a, output logic [7:0] d,
    output logic o);
    @(negedge sys_clk);
    {cs0_n, cs1_n, da} = {c0, c1, a};
    repeat (4) @(negedge sys_clk);
    dior_n = 1'b0;
    repeat (7) @(negedge sys_clk);
    d = dd;
    o = !dd_oe_n;
    dior_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    {cs0_n, cs1_n} = 2'h3;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

// ===== verification/test_overlap_select_interrupt_logic.sv
// self-checking bench for the overlap select and interrupt logic
`timescale 1ns/1ps
module test_overlap_select_interrupt_logic
  import osil_pkg::*;
;
  logic sys_clk, rst_n, cs0_n, cs1_n, diow_n, dior_n, dd_oe_n, strap, class_data;
  logic intrq_out, intrq_oe_n, sec_out, sec_oe_n, cmd_valid, param_valid, soft_reset, roe;
  logic [2:0] da;
  logic [7:0] dd, dd_out, cmd_opcode, param_count, param_head, rdat;
  logic [5:0] fwv;
  logic [1:0] mode_sel;
  osil_mode_t mode;
  int n_mismatch = 0;
  int tests_run = 0;
  int cmd_n = 0;
  int par_n = 0;
  int soft_n = 0;
  osil_host_model host(.sys_clk(sys_clk), .dd_out(dd_out), .dd_oe_n(dd_oe_n), .cs0_n(cs0_n),
    .cs1_n(cs1_n), .diow_n(diow_n), .dior_n(dior_n), .da(da), .dd(dd));
  osil_core uut(.sys_clk(sys_clk), .rst_n(rst_n), .cs0_n_pin(cs0_n), .cs1_n_pin(cs1_n),
    .diow_n_pin(diow_n), .dior_n_pin(dior_n), .da_pin(da), .dd_in(dd), .dd_out(dd_out),
    .dd_oe_n(dd_oe_n), .intrq_out(intrq_out), .intrq_oe_n(intrq_oe_n),
    .second_device_interrupt_out(sec_out), .second_device_interrupt_oe_n(sec_oe_n),
    .position_strap(strap), .fw_mode_set(fwv[0]), .fw_mode_sel(mode_sel),
    .fw_class_valid(fwv[1]), .fw_class_data(class_data), .fw_drq_set(fwv[2]),
    .fw_drq_clr(fwv[3]), .fw_done(fwv[4]), .fw_error(1'b0), .fw_intr_req(fwv[5]),
    .mode(mode), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .param_valid(param_valid),
    .param_features(), .param_count(param_count), .param_sector(), .param_cyl_lo(),
    .param_cyl_hi(), .param_head(param_head), .queue_abort(), .soft_reset(soft_reset));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (cmd_valid === 1'b1) cmd_n++;
    if (param_valid === 1'b1) par_n++;
    if (soft_reset === 1'b1) soft_n++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fwp(input int k);
    @(negedge sys_clk);
    fwv[k] = 1'b1;
    @(negedge sys_clk);
    fwv[k] = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic set_mode(input logic [1:0] s);
    mode_sel = s;
    fwp(0);
  endtask
  // masked read; e is only compared when the device should answer
  task automatic rdc(input logic c0, input logic c1, input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] e, input logic eo, input string n);
    host.rd(c0, c1, a, rdat, roe);
    chk({n, "_oe"}, {7'h00, eo}, {7'h00, roe});
    if (eo)
      chk(n, e, rdat & m);
  endtask
  task automatic hard_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fwv = 6'h00;
    mode_sel = 2'h0;
    class_data = 1'b1;
    hard_reset(1'b0);
    chk("mode", 8'h00, {6'h00, mode});
    rdc(1'b0, 1'b1, REG_HEAD, 8'hFF, HEAD_RST, 1'b1, "head");
    rdc(1'b1, 1'b1, REG_HEAD, 8'hFF, 8'h00, 1'b0, "unused");
    // legacy data command stays busy, then data request, then idle
    host.wr(1'b0, 1'b1, REG_COMMAND, 8'h20);
    chk("cmd", 8'h01, 8'(cmd_n));
    chk("op", 8'h20, cmd_opcode);
    fwp(1);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h80, 1'b1, "bsy");
    chk("par_leg", 8'h00, 8'(par_n));
    fwp(2);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h08, 1'b1, "drq");
    fwp(4);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h00, 1'b1, "idle");
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hB0);
    host.wr(1'b0, 1'b1, REG_COMMAND, 8'h20);
    chk("cmd_dev1", 8'h01, 8'(cmd_n));
    rdc(1'b0, 1'b1, REG_COMMAND, 8'hFF, 8'h00, 1'b0, "st_dev1");
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hA0);
    for (int k = 0; k < 4; k++)
    begin
      set_mode(k[1:0]);
      chk("mode_k", {6'h00, (k == 3) ? 2'h0 : k[1:0]}, {6'h00, mode});
    end
    set_mode(2'h1);
    host.wr(1'b0, 1'b1, REG_COUNT, 8'h07);
    host.wr(1'b0, 1'b1, REG_COMMAND, 8'hC8);
    fwp(1);
    chk("par_n", 8'h01, 8'(par_n));
    chk("count", 8'h07, param_count);
    chk("head_p", 8'hA0, param_head);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h00, 1'b1, "early");
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hB0);
    rdc(1'b0, 1'b1, REG_HEAD, 8'hFF, 8'h00, 1'b0, "sel_other");
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hA0);
    host.wr(1'b0, 1'b1, REG_COMMAND, 8'hC8);
    chk("queued", 8'h03, 8'(cmd_n));
    class_data = 1'b0;
    fwp(1);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h80, 1'b1, "nodata");
    fwp(4);
    fwp(5);
    chk("int_sel", 8'h01, {6'h00, intrq_oe_n, intrq_out});
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hB0);
    chk("int_unsel", 8'h01, {7'h00, intrq_oe_n});
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hA0);
    chk("int_back", 8'h01, {6'h00, intrq_oe_n, intrq_out});
    set_mode(2'h2);
    rdc(1'b1, 1'b1, REG_DEV_CTRL, 8'h88, 8'h00, 1'b1, "d0_ctl");
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h00, 1'b0, "d1_ctl");
    rdc(1'b0, 1'b1, REG_HEAD, 8'hFF, 8'hA0, 1'b1, "d0_cmd");
    rdc(1'b0, 1'b0, REG_HEAD, 8'hFF, 8'h00, 1'b0, "d1_cmd");
    host.wr(1'b0, 1'b1, REG_HEAD, 8'hB0);
    rdc(1'b0, 1'b1, REG_COMMAND, 8'h88, 8'h00, 1'b1, "st_clr");
    chk("int_clr", 8'h00, {6'h00, intrq_oe_n, intrq_out});
    fwp(5);
    chk("int_cs", 8'h01, {6'h00, intrq_oe_n, intrq_out});
    chk("int_sec", 8'h01, {7'h00, sec_oe_n});
    host.wr(1'b1, 1'b1, REG_DEV_CTRL, 8'h04);
    chk("soft", 8'h01, 8'(soft_n));
    chk("mode_soft", 8'h02, {6'h00, mode});
    host.wr(1'b1, 1'b1, REG_DEV_CTRL, 8'h00);
    hard_reset(1'b1);
    chk("mode_hard", 8'h00, {6'h00, mode});
    set_mode(2'h2);
    rdc(1'b1, 1'b0, REG_DEV_CTRL, 8'h88, 8'h00, 1'b1, "d1_own");
    fwp(5);
    chk("sec_int", 8'h01, {6'h00, sec_oe_n, sec_out});
    chk("int_free", 8'h01, {7'h00, intrq_oe_n});
    test_done;
  end
endmodule
